// >>> core/sar_adc_sequencer.sv
// Converter sequencer with bus registers, port pin override and assertions
//
// Summary of operation
// RULE1: Selected pin forced to converter input
// RULE2: Port writes never touch the selected pin
// RULE3: Port read of selected pin returns zero
// RULE4: Full scale 3ff, zero 000, linear
// RULE5: Every control register write starts conversion; the code starts none when the write selects CH_OFF
// RULE6: Conversion ends after 16-17 converter clocks
// RULE7: Software picks divider for about 1 MHz
// RULE8: Continuous mode overwrites result every conversion
// RULE9: Continuous conversions repeat until bit cleared
// RULE10: Done flag set, held until data read
// RULE11: Single mode: one conversion per write
// RULE12: Software discards result of interrupted conversion
// RULE13: Four result formats via two-bit field
// RULE14: Left format: bits 9-2 high, 1-0 low top
// RULE15: High read locks results until low read
// RULE16: Right format: two MSBs high, eight low
// RULE17: Signed format inverts the top result bit
// RULE18: Truncation: eight MSBs low, no interlock
// RULE19: Interrupt enabled: request irq, no flag
// RULE20: Keeps converting in wait, irq wakes
// RULE21: Software powers down before wait if unneeded
// RULE22: Stop aborts; first resumed conversion settles
// RULE23: Channel codes: pins, references, power off
// RULE24: Flag reads zero with irq; read clears
// RULE25: Irq withdrawn on data read or write
// RULE26: Reset clears enables, selects power off
// RULE27: Write mid-conversion restarts with new settings
// RULE28: Converter clock is divided, bus synchronous
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
module sar_adc_sequencer
  import sar_adc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic stop_mode,
  input wire logic alt_clk_in,
  input wire logic comp_above,
  output logic [4:0] channel_select_field,
  output logic conv_power,
  output logic sample_en,
  output logic [9:0] dac_code,
  output logic conv_irq,
  input wire logic [23:0] port_pin_in,
  output logic [23:0] port_pin_out,
  output logic [23:0] port_pin_oe
);
  typedef struct packed {
    logic hready, hresp, pend, pwrite;
    logic [31:0] hrdata;
    logic [7:0] paddr;
    logic conv_irq_enable, continuous_conv_bit, conv_done_flag, irq;
    logic [4:0] chan;
    logic [2:0] div;
    logic src;
    fmt_t fmt;
    logic [7:0] res_hi, res_lo;
    logic hi_lock, active, settle, resume, stop_d, power, sample;
    logic [23:0] port_latch, port_dir, pin_out, pin_oe, pin_s1, pin_s2;
    logic [3:0] cnt, div_cnt;
    logic [9:0] trial;
    logic comp_s1, comp_s2, alt_s1, alt_s2, alt_d;
  } state_t;
  function automatic state_t rst_val();
    state_t r;
    r = '0;
    r.hready = 1'b1;
    r.conv_irq_enable = SCR_RESET[SCR_IRQ_EN_BIT];
    r.continuous_conv_bit = SCR_RESET[SCR_CONT_BIT];
    r.chan = SCR_RESET[CH_W-1:0];
    r.div = CLK_CFG_RESET[CLK_DIV_LSB +: DIV_W];
    r.src = CLK_CFG_RESET[CLK_SRC_BIT];
    r.fmt = fmt_t'(CLK_CFG_RESET[CLK_FMT_LSB +: 2]);
    return r;
  endfunction

  localparam state_t ST_RST = rst_val();

  // One-hot of the port pin that the converter owns, if any
  function automatic logic [23:0] chan_mask(input logic [4:0] ch);
    logic [23:0] m;
    m = '0;
    if (ch < 5'(PIN_COUNT)) begin
      m[ch] = 1'b1;
    end
    return m;
  endfunction

  // Last divider count for each divider code
  function automatic logic [3:0] div_last(input logic [2:0] d);
    case (d)
      3'h0: div_last = 4'h0;
      3'h1: div_last = 4'h1;
      3'h2: div_last = 4'h3;
      3'h3: div_last = 4'h7;
      default: div_last = 4'hf;
    endcase
  endfunction

  // Places a result into the high and low registers
  function automatic logic [15:0] place(input logic [9:0] r, input fmt_t f);
    case (f)
      FMT_LEFT: place = {r[9:2], r[1:0], 6'h00}; // [RULE14]
      FMT_RIGHT: place = {6'h00, r[9:8], r[7:0]}; // [RULE16]
      FMT_SIGNED: place = {~r[9], r[8:2], r[1:0], 6'h00}; // [RULE17]
      default: place = {8'h00, r[9:2]}; // [RULE18]
    endcase
  endfunction
  state_t s;
  state_t n;
  logic wr_scr, rd_res, pulse, tick, finish, go;
  logic [3:0] bit_idx;
  logic [9:0] res;
  logic [15:0] placed;
  always_comb begin
    n = s;
    wr_scr = 1'b0;
    rd_res = 1'b0;
    pulse = 1'b0;
    tick = 1'b0;
    finish = 1'b0;
    go = 1'b0;
    bit_idx = 4'h0;
    res = s.trial;
    placed = 16'h0000;
    // Two-flop synchronisers for the port pins, comparator and alternate clock; stop_mode is used unsynchronised
    n.pin_s1 = port_pin_in;
    n.pin_s2 = s.pin_s1;
    n.comp_s1 = comp_above;
    n.comp_s2 = s.comp_s1;
    n.alt_s1 = alt_clk_in;
    n.alt_s2 = s.alt_s1;
    n.alt_d = s.alt_s2;
    n.stop_d = stop_mode;

    // Bus: one wait state so read data reflects the preceding write
    n.hready = 1'b1;
    n.pend = 1'b0;
    if (s.pend) begin
      n.hrdata = 32'h0000_0000;
      if (s.pwrite) begin
        case (s.paddr)
          ADDR_SCR: begin
            wr_scr = 1'b1;
            n.conv_irq_enable = hwdata[SCR_IRQ_EN_BIT];
            n.continuous_conv_bit = hwdata[SCR_CONT_BIT];
            n.chan = hwdata[CH_W-1:0]; // [RULE23]
          end
          ADDR_CLK_CFG: begin
            n.div = hwdata[CLK_DIV_LSB +: DIV_W];
            n.src = hwdata[CLK_SRC_BIT];
            n.fmt = fmt_t'(hwdata[CLK_FMT_LSB +: 2]); // [RULE13]
          end
          ADDR_PORT_LATCH: n.port_latch = hwdata[PIN_COUNT-1:0];
          ADDR_PORT_DIR: n.port_dir = hwdata[PIN_COUNT-1:0];
          default: ;
        endcase
      end else begin
        case (s.paddr)
          ADDR_SCR: n.hrdata = {24'h000000,
            s.conv_done_flag & ~s.conv_irq_enable, // [RULE24]
            s.conv_irq_enable, s.continuous_conv_bit, s.chan};
          ADDR_RES_HI: begin
            n.hrdata = {24'h000000, s.res_hi};
            rd_res = 1'b1;
            // Truncation format has no high/low pairing
            if (s.fmt != FMT_TRUNC) begin
              n.hi_lock = 1'b1; // [RULE15]
            end
          end
          ADDR_RES_LO: begin
            n.hrdata = {24'h000000, s.res_lo};
            rd_res = 1'b1;
            n.hi_lock = 1'b0; // [RULE15]
          end
          ADDR_CLK_CFG: n.hrdata = {24'h000000, s.div, s.src, s.fmt, 2'b00};
          ADDR_PORT_LATCH: n.hrdata = {8'h00, s.port_latch};
          ADDR_PORT_DIR: n.hrdata = {8'h00, s.port_dir};
          ADDR_PORT_IN: n.hrdata = {8'h00, s.pin_s2 & ~chan_mask(s.chan)}; // [RULE3]
          default: ;
        endcase
      end
    end else if (hsel && hready && htrans[1]) begin
      n.pend = 1'b1;
      n.pwrite = hwrite;
      n.paddr = haddr[7:0];
      n.hready = 1'b0;
    end
    // Clears go first so that a completion in the same cycle wins
    if (rd_res) begin
      n.conv_done_flag = 1'b0; // [RULE10] [RULE24]
    end
    if (rd_res || wr_scr) begin
      n.irq = 1'b0; // [RULE25]
    end
    // Converter clock: bus clock or the alternate clock, then divided
    if (s.active) begin
      pulse = s.src ? (s.alt_s2 & ~s.alt_d) : 1'b1;
      if (pulse) begin
        if (s.div_cnt == div_last(s.div)) begin
          tick = 1'b1; // [RULE28]
          n.div_cnt = 4'h0;
        end else begin
          n.div_cnt = s.div_cnt + 4'h1;
        end
      end
    end
    // Sample for five ticks, then resolve one bit per tick, MSB first
    if (tick) begin
      n.cnt = s.cnt + 4'h1;
      if (s.cnt == SAMPLE_TICKS) begin
        n.trial = 10'h200;
      end else if (s.cnt > SAMPLE_TICKS) begin
        bit_idx = CONV_LAST - s.cnt;
        if (!s.comp_s2) begin
          res[bit_idx] = 1'b0; // [RULE4]
        end
        if (bit_idx != 4'h0) begin
          res[bit_idx - 4'h1] = 1'b1;
        end
        n.trial = res;
      end
      finish = (s.cnt == CONV_LAST); // [RULE6]
    end
    if (finish) begin
      placed = place(res, s.fmt);
      if (s.settle) begin
        // Settling pass after power-up or stop: result is thrown away
        n.settle = 1'b0; // [RULE22]
      end else begin
        if (!s.hi_lock || s.fmt == FMT_TRUNC) begin
          n.res_hi = placed[15:8]; // [RULE8] [RULE15]
          n.res_lo = placed[7:0];
        end
        if (s.conv_irq_enable) begin
          n.irq = 1'b1; // [RULE19] [RULE20]
        end else begin
          n.conv_done_flag = 1'b1; // [RULE10]
        end
        n.active = s.continuous_conv_bit; // [RULE9] [RULE11]
      end
    end
    // Stop mode: abandon the conversion, remember to resume later
    if (stop_mode && !s.stop_d) begin
      n.resume = s.active | s.continuous_conv_bit;
      n.settle = 1'b1;
    end
    go = (wr_scr && n.chan != CH_OFF) ||
         (s.stop_d && !stop_mode && s.resume && s.chan != CH_OFF);
    if (wr_scr && s.chan == CH_OFF && n.chan != CH_OFF) begin
      n.settle = 1'b1; // [RULE22]
    end
    if (wr_scr && n.chan == CH_OFF) begin
      n.active = 1'b0; // [RULE23]
    end
    if (go) begin
      n.active = 1'b1; // [RULE5] [RULE27]
      n.resume = 1'b0;
      n.cnt = 4'h0;
      n.div_cnt = 4'h0;
      n.trial = 10'h000;
    end
    if (stop_mode) begin
      n.active = 1'b0; // [RULE22]
    end
    // Selected pin leaves port control; others follow latch and direction
    n.pin_oe = n.port_dir & ~chan_mask(n.chan); // [RULE1] [RULE2]
    n.pin_out = n.port_latch & ~chan_mask(n.chan); // [RULE2]
    n.power = (n.chan != CH_OFF) && !stop_mode; // [RULE26]
    n.sample = n.active && (n.cnt < SAMPLE_TICKS);
  end
  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= ST_RST; // [RULE26]
    end else begin
      s <= n;
    end
  end
  assign hreadyout = s.hready;
  assign hrdata = s.hrdata;
  assign hresp = s.hresp;
  assign channel_select_field = s.chan;
  assign conv_power = s.power;
  assign sample_en = s.sample;
  assign dac_code = s.trial;
  assign conv_irq = s.irq;
  assign port_pin_out = s.pin_out;
  assign port_pin_oe = s.pin_oe;
  // Ticks seen since a conversion began, checked against completion
  logic [4:0] tick_seen;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_seen <= 5'h00;
    end else if (go || finish) begin
      tick_seen <= 5'h00;
    end else if (tick) begin
      tick_seen <= tick_seen + 5'h01;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_pin_override;
    s.chan < 5'(PIN_COUNT) |-> !port_pin_oe[s.chan] && !port_pin_out[s.chan];
  endproperty
  a_pin_override: assert property (p_pin_override) // [RULE1]
    else $error("selected pin still driven by port");
  property p_port_follow;
    (port_pin_oe | chan_mask(s.chan)) == (s.port_dir | chan_mask(s.chan));
  endproperty
  a_port_follow: assert property (p_port_follow) // [RULE2]
    else $error("unselected pin not following direction");
  property p_port_read;
    s.pend && !s.pwrite && s.paddr == ADDR_PORT_IN &&
      s.chan < 5'(PIN_COUNT) |=> hrdata[$past(s.chan)] == 1'b0;
  endproperty
  a_port_read: assert property (p_port_read) // [RULE3]
    else $error("selected pin read not zero");
  property p_start;
    wr_scr && n.chan != CH_OFF && !stop_mode |=> s.active && s.cnt == 4'h0;
  endproperty
  a_start: assert property (p_start) // [RULE5]
    else $error("write did not start a conversion");
  property p_length;
    finish |-> tick_seen == 5'(CONV_TICKS - 1) && tick;
  endproperty
  a_length: assert property (p_length) // [RULE6]
    else $error("conversion length wrong");
  property p_left;
    finish && !s.settle && !s.hi_lock && s.fmt == FMT_LEFT |=>
      s.res_hi == $past(res[9:2]) && s.res_lo == {$past(res[1:0]), 6'h00};
  endproperty
  a_left: assert property (p_left) // [RULE14]
    else $error("left format placement wrong");
  property p_signed;
    finish && !s.settle && !s.hi_lock && s.fmt == FMT_SIGNED |=>
      s.res_hi[7] == !$past(res[9]);
  endproperty
  a_signed: assert property (p_signed) // [RULE17]
    else $error("signed format top bit not inverted");
  property p_trunc;
    finish && !s.settle && s.fmt == FMT_TRUNC |=>
      s.res_lo == $past(res[9:2]);
  endproperty
  a_trunc: assert property (p_trunc) // [RULE18]
    else $error("truncation ignored or misplaced");
  property p_lock;
    s.hi_lock && s.fmt != FMT_TRUNC |=> $stable(s.res_hi) && $stable(s.res_lo);
  endproperty
  a_lock: assert property (p_lock) // [RULE15]
    else $error("result stored while interlocked");
  property p_flag;
    finish && !s.settle && !s.conv_irq_enable |=>
      s.conv_done_flag && !conv_irq;
  endproperty
  a_flag: assert property (p_flag) // [RULE10]
    else $error("done flag not set");
  property p_irq;
    finish && !s.settle && s.conv_irq_enable |=>
      conv_irq && !$changed(s.conv_done_flag);
  endproperty
  a_irq: assert property (p_irq) // [RULE19]
    else $error("interrupt not raised");
  property p_irq_clear;
    (rd_res || wr_scr) && !finish |=> !conv_irq;
  endproperty
  a_irq_clear: assert property (p_irq_clear) // [RULE25]
    else $error("interrupt not withdrawn");
  property p_stop;
    stop_mode |=> !s.active ##1 !s.active || !stop_mode;
  endproperty
  a_stop: assert property (p_stop) // [RULE22]
    else $error("conversion running in stop");
  cover property (finish && !s.settle && s.continuous_conv_bit);
  cover property (finish && s.settle);
  cover property (finish && s.hi_lock && s.fmt == FMT_RIGHT);
  cover property (stop_mode && s.active);
endmodule

// >>> core/sar_adc_pkg.sv
// Constants shared by the successive-approximation converter sequencer
package sar_adc_pkg;
  // Register byte addresses on the bus
  localparam logic [7:0] ADDR_SCR = 8'h3c;
  localparam logic [7:0] ADDR_RES_HI = 8'h40;
  localparam logic [7:0] ADDR_RES_LO = 8'h44;
  localparam logic [7:0] ADDR_CLK_CFG = 8'h48;
  localparam logic [7:0] ADDR_PORT_LATCH = 8'h4c;
  localparam logic [7:0] ADDR_PORT_DIR = 8'h50;
  localparam logic [7:0] ADDR_PORT_IN = 8'h54;

  // Widths
  localparam int RES_W = 10;
  localparam int PIN_COUNT = 24;
  localparam int CH_W = 5;
  localparam int DIV_W = 3;

  // Channel codes with special meaning
  localparam logic [4:0] CH_UPPER_REF = 5'h1d;
  localparam logic [4:0] CH_LOWER_REF = 5'h1e;
  localparam logic [4:0] CH_OFF = 5'h1f;

  // Field positions, status/control register
  localparam int SCR_DONE_BIT = 7;
  localparam int SCR_IRQ_EN_BIT = 6;
  localparam int SCR_CONT_BIT = 5;
  // Field positions, clock configuration register
  localparam int CLK_DIV_LSB = 5;
  localparam int CLK_SRC_BIT = 4;
  localparam int CLK_FMT_LSB = 2;

  // Reset values
  localparam logic [7:0] SCR_RESET = 8'h1f;
  localparam logic [7:0] CLK_CFG_RESET = 8'h00;

  // Sequencing counts in converter clock ticks
  localparam logic [3:0] SAMPLE_TICKS = 4'h5;
  localparam int CONV_TICKS = 16;
  localparam logic [3:0] CONV_LAST = 4'(CONV_TICKS - 1);

  // Result formats
  typedef enum logic [1:0] {
    FMT_LEFT,
    FMT_RIGHT,
    FMT_SIGNED,
    FMT_TRUNC
  } fmt_t;
endpackage

// >>> tb/analog_src.sv
// Analog sources and pulled-up port pads around the converter
`timescale 1ns/100ps
module analog_src (
  input wire logic [4:0] channel_select_field,
  input wire logic conv_power,
  input wire logic [9:0] dac_code,
  input wire logic [9:0] pin_code,
  input wire logic [23:0] port_pin_out,
  input wire logic [23:0] port_pin_oe,
  output logic comp_above,
  output logic [23:0] port_pin_in
);
  real vin;
  // Half an LSB above the code keeps every trial away from a tie
  always_comb begin
    if (channel_select_field == 5'h1d) begin
      vin = 1023.5;
    end else if (channel_select_field == 5'h1e) begin
      vin = 0.0;
    end else begin
      vin = real'(pin_code) + 0.5;
    end
    // A powered-down comparator gives no useful answer
    comp_above = conv_power && (vin > real'(dac_code));
  end
  // Undriven pads float up through their pull-ups
  assign port_pin_in = (port_pin_out & port_pin_oe) | ~port_pin_oe;
endmodule

// >>> tb/tb.sv
// Bus-level testbench for the converter sequencer
`timescale 1ns/100ps
module tb;
  import sar_adc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic stop_mode = 1'b0;
  logic alt_clk = 1'b0;
  logic [9:0] pin_code = 10'h2b6;
  logic hreadyout, hresp, conv_power, sample_en, conv_irq, comp_above;
  logic [31:0] hrdata, rv, hi, lo;
  logic [4:0] chan;
  logic [9:0] dac_code;
  logic [23:0] pin_in, pin_out, pin_oe;
  logic [15:0] e;
  int n_mismatch = 0;
  int checks_done = 0;
  int n;
  logic [4:0] t_ch [6] = '{5'h05, 5'h05, 5'h05, 5'h05, 5'h1d, 5'h1e};
  logic [1:0] t_f [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h1};
  logic [9:0] t_r [6] = '{10'h2b6, 10'h2b6, 10'h2b6, 10'h2b6, 10'h3ff, 10'h0};

  always #25 hclk = ~hclk;
  // Alternate converter clock; its edges never meet a rising bus clock edge
  always #80 alt_clk = ~alt_clk;

  sar_adc_sequencer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .stop_mode(stop_mode),
    .alt_clk_in(alt_clk), .comp_above(comp_above),
    .channel_select_field(chan), .conv_power(conv_power),
    .sample_en(sample_en), .dac_code(dac_code), .conv_irq(conv_irq),
    .port_pin_in(pin_in), .port_pin_out(pin_out), .port_pin_oe(pin_oe));

  analog_src i_src (.channel_select_field(chan), .conv_power(conv_power),
    .dac_code(dac_code), .pin_code(pin_code), .port_pin_out(pin_out),
    .port_pin_oe(pin_oe), .comp_above(comp_above), .port_pin_in(pin_in));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stuck(string what);
    n_mismatch++;
    $display("BAD %s timeout", what);
    end_sim();
  endtask

  // Sample hready at each rising edge; a bus that never answers ends the run
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 20) begin
        stuck("hready");
      end
      @(posedge hclk);
    end
  endtask

  // One single AHB transfer: address phase, then data phase
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rv = hrdata;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  // Poll the done flag; polling reads never clear it
  task automatic wait_done();
    for (int k = 0; k < 300; k++) begin
      rd(ADDR_SCR);
      if (rv[SCR_DONE_BIT] === 1'b1) begin
        return;
      end
    end
    stuck("done");
  endtask

  task automatic wait_irq();
    n = 0;
    while (conv_irq !== 1'b1) begin
      @(posedge hclk);
      n++;
      if (n > 300) begin
        stuck("irq");
      end
    end
  endtask

  task automatic get_res();
    rd(ADDR_RES_HI);
    hi = rv;
    rd(ADDR_RES_LO);
    lo = rv;
  endtask

  // Expected {high, low} register bytes for a code in a given format
  function automatic logic [15:0] fmt_exp(logic [9:0] r, logic [1:0] f);
    case (f)
      2'h0: return {r[9:2], r[1:0], 6'h0};
      2'h1: return {6'h0, r[9:8], r[7:0]};
      2'h2: return {~r[9], r[8:2], r[1:0], 6'h0};
      default: return {8'h0, r[9:2]};
    endcase
  endfunction

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset state and an unmapped read
    rd(ADDR_SCR);
    chk("scr_reset", rv, 32'h1f);
    chk("power_reset", conv_power, 1'b0);
    chk("hresp", hresp, 1'b0);
    rd(8'h00);
    chk("unmapped", rv, 32'h0);
    // Divide by four sets the converter clock to a quarter of the bus clock
    wr(ADDR_CLK_CFG, 32'h40);
    // Selected pin leaves port control, others follow the latch
    wr(ADDR_PORT_LATCH, 32'hffffff);
    wr(ADDR_PORT_DIR, 32'hffffff);
    wr(ADDR_SCR, 32'h03);
    repeat (2) @(posedge hclk);
    chk("pin_out", pin_out, 24'hfffff7);
    chk("pin_oe", pin_oe, 24'hfffff7);
    chk("chan", chan, 5'h03);
    rd(ADDR_PORT_IN);
    chk("port_in", rv, 32'hfffff7);
    wait_done();
    // Reading the result also clears the flag before the format loop
    get_res();
    chk("first_hi", hi, 32'had);
    chk("first_lo", lo, 32'h80);
    // Every format, plus both references
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_CLK_CFG, {24'h0, 3'h2, 1'b0, t_f[i], 2'h0});
      wr(ADDR_SCR, {27'h0, t_ch[i]});
      wait_done();
      get_res();
      e = fmt_exp(t_r[i], t_f[i]);
      chk("res_hi", hi, {24'h0, e[15:8]});
      chk("res_lo", lo, {24'h0, e[7:0]});
      rd(ADDR_SCR);
      chk("flag_clr", rv[SCR_DONE_BIT], 1'b0);
    end
    // High read alone holds the result against a new conversion
    wr(ADDR_CLK_CFG, 32'h40);
    wr(ADDR_SCR, 32'h05);
    wait_done();
    rd(ADDR_RES_HI);
    pin_code <= 10'h0c9;
    wr(ADDR_SCR, 32'h05);
    wait_done();
    get_res();
    get_res();
    e = fmt_exp(10'h2b6, 2'h0);
    chk("lock_hi", hi, {24'h0, e[15:8]});
    chk("lock_lo", lo, {24'h0, e[7:0]});
    // Truncation never locks
    wr(ADDR_CLK_CFG, 32'h4c);
    wr(ADDR_SCR, 32'h05);
    wait_done();
    rd(ADDR_RES_HI);
    pin_code <= 10'h2b6;
    wr(ADDR_SCR, 32'h05);
    wait_done();
    rd(ADDR_RES_LO);
    chk("trunc_lo", rv, 32'had);
    // Interrupt mode: timing, flag masking, withdrawal
    wr(ADDR_SCR, 32'h45);
    wait_irq();
    chk("conv_time", 32'(n >= 62 && n <= 70), 32'h1);
    rd(ADDR_SCR);
    chk("flag_irq", rv[SCR_DONE_BIT], 1'b0);
    chk("irq_held", conv_irq, 1'b1);
    wr(ADDR_SCR, 32'h45);
    chk("irq_wr_clr", conv_irq, 1'b0);
    wait_irq();
    rd(ADDR_RES_LO);
    chk("irq_rd_clr", conv_irq, 1'b0);
    // Continuous mode overwrites without any further write
    wr(ADDR_SCR, 32'h25);
    wait_done();
    rd(ADDR_RES_LO);
    chk("cont_a", rv, 32'had);
    pin_code <= 10'h0c9;
    // The conversion straddling the input change is thrown away
    wait_done();
    rd(ADDR_RES_LO);
    wait_done();
    rd(ADDR_RES_LO);
    chk("cont_b", rv, 32'h32);
    // Single mode: one conversion, then idle
    wr(ADDR_SCR, 32'h05);
    chk("sample_on", sample_en, 1'b1);
    wait_done();
    rd(ADDR_RES_LO);
    repeat (200) @(posedge hclk);
    rd(ADDR_SCR);
    chk("single", rv[SCR_DONE_BIT], 1'b0);
    chk("sample_off", sample_en, 1'b0);
    // Rewrite mid-conversion restarts on the new channel
    wr(ADDR_SCR, 32'h05);
    repeat (20) @(posedge hclk);
    wr(ADDR_SCR, 32'h1d);
    wait_done();
    rd(ADDR_RES_LO);
    chk("restart", rv, 32'hff);
    // Stop aborts, conversion resumes after a settle pass
    wr(ADDR_SCR, 32'h05);
    repeat (10) @(posedge hclk);
    stop_mode <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("stop_pwr", conv_power, 1'b0);
    repeat (200) @(posedge hclk);
    rd(ADDR_SCR);
    chk("stop_flag", rv[SCR_DONE_BIT], 1'b0);
    stop_mode <= 1'b0;
    wait_done();
    rd(ADDR_RES_LO);
    chk("stop_res", rv, 32'h32);
    // Undivided alternate source paces the converter near bus/3
    wr(ADDR_CLK_CFG, 32'h1c);
    wr(ADDR_SCR, 32'h05);
    wait_done();
    rd(ADDR_RES_LO);
    chk("alt_src", rv, 32'h32);
    // All-ones channel powers the converter off
    wr(ADDR_SCR, 32'h1f);
    repeat (3) @(posedge hclk);
    chk("off_pwr", conv_power, 1'b0);
    end_sim();
  end
endmodule
